// ---- design/ddr3_cmd_map.svh ----
// Pin encodings, field positions and timing counts of the command issuer
// Behaviour
// - Command is CKE previous/current, CS, RAS, CAS, WE at rising clock edge.
// - Mode register set: CKE high twice, all four strobes low; bank picks register.
// - Activate: CS, RAS low, CAS, WE high; bank and row on pins.
// - Precharge: CS, RAS, WE low, CAS high; AP high closes every bank.
// - Write: CS, CAS, WE low, RAS high, AP low; column on low pins.
// - On-the-fly burst: A12 low chops to four beats, high gives eight.
// - Write with AP high closes the bank after the burst.
// - Read: CS, CAS low, RAS, WE high, AP low; column and chop as write.
// - Read with AP high closes the bank after the burst.
// - Refresh encoding with CKE falling enters self-refresh; no termination there.
// - Self-refresh exit: CKE rises with no-operation or deselect presented.
// - Power-down enters on CKE fall, leaves on rise, with no-operation or deselect.
// - No-operation registers nothing; issue it whenever idle or waiting.
// - ZQ calibration: CS, WE low, RAS, CAS high; AP selects long or short.
// - Pins the device ignores are still driven to defined levels.
// - A started burst runs to completion uninterrupted.
// - Active-low reset pin is only an asynchronous reset; held high otherwise.
// - While pattern readout mode is on, only reads are issued; the issuer also takes mode register 3 writes there.
// - Self-refresh entry only when all banks are idle.
`ifndef DDR3_CMD_MAP_SVH
`define DDR3_CMD_MAP_SVH
`define ADDR_W       15
`define BA_W         3
`define AP_BIT       10
`define BC_BIT       12
`define MR3_BA       3'h3
`define MPR_BIT      2
`define BURST_CYC    4'h4
`define CHOP_CYC     4'h2
`define CKE_MIN_CYC  4'h3
`endif

// ---- design/ddr3_cmd_pkg.sv ----
// Types shared by the command issuer
package ddr3_cmd_pkg;
    typedef enum logic [3:0] {
        OP_NOP     = 4'h0,
        OP_MRS     = 4'h1,
        OP_REF     = 4'h2,
        OP_SRE     = 4'h3,
        OP_SRX     = 4'h4,
        OP_ACT     = 4'h5,
        OP_PRE     = 4'h6,
        OP_ALL_BANK_CLOSE_CMD    = 4'h7,
        OP_WR      = 4'h8,
        OP_RD      = 4'h9,
        OP_PDE     = 4'hA,
        OP_PDX     = 4'hB,
        OP_ZQ      = 4'hC,
        OP_DES     = 4'hD
    } op_e;
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_BURST = 4'b0010,
        ST_PD    = 4'b0100,
        ST_SR    = 4'b1000
    } state_e;
endpackage

// ---- design/ddr3_cmd_issuer.sv ----
// Controller side that drives DDR3 command and address pins
`timescale 1ns/100ps
`include "ddr3_cmd_map.svh"
module ddr3_cmd_issuer (
    input  wire logic                     sys_clk,
    input  wire logic                     sys_rst,
    input  wire logic                     clk_en,
    input  wire logic                     req_valid,
    input  wire ddr3_cmd_pkg::op_e        req_op,
    input  wire logic [`BA_W-1:0]         req_bank,
    input  wire logic [`ADDR_W-1:0]       req_addr,
    input  wire logic                     req_auto_close,
    input  wire logic                     req_full,
    input  wire logic                     otf_enable,
    input  wire logic                     dram_reset_req,
    output logic                          req_ready,
    output logic                          req_refused,
    output logic                          cke,
    output logic                          cs_n,
    output logic                          ras_n,
    output logic                          cas_n,
    output logic                          we_n,
    output logic [`BA_W-1:0]              ba,
    output logic [`ADDR_W-1:0]            addr,
    output logic                          dram_reset_n,
    output logic                          odt_allowed,
    output logic                          mpr_active,
    output logic                          banks_open
);
    import ddr3_cmd_pkg::*;

    state_e              state_q, state_d;
    logic                cke_q;
    logic                cs_n_q, ras_n_q, cas_n_q, we_n_q;
    logic [`BA_W-1:0]    ba_q;
    logic [`ADDR_W-1:0]  addr_q;
    logic [3:0]          burst_q;
    logic [3:0]          hold_q;
    logic                mpr_q;
    logic [7:0]          open_q;
    logic                rst_n_q;

    // Strobes as {cs_n, ras_n, cas_n, we_n}
    function automatic logic [3:0] strobes(input op_e op);
        case (op)
            OP_MRS:  strobes = 4'h0;
            OP_REF:  strobes = 4'h1;
            OP_SRE:  strobes = 4'h1;
            OP_ACT:  strobes = 4'h3;
            OP_PRE:  strobes = 4'h2;
            OP_ALL_BANK_CLOSE_CMD: strobes = 4'h2;
            OP_WR:   strobes = 4'h4;
            OP_RD:   strobes = 4'h5;
            OP_ZQ:   strobes = 4'h6;
            OP_DES:  strobes = 4'hF;
            default: strobes = 4'h7;
        endcase
    endfunction

    wire is_burst  = (req_op == OP_WR) || (req_op == OP_RD);
    wire is_sre    = (req_op == OP_SRE);
    wire is_pde    = (req_op == OP_PDE);
    wire is_exit   = (req_op == OP_SRX) || (req_op == OP_PDX);
    wire is_idle   = (req_op == OP_NOP) || (req_op == OP_DES);
    wire st_idle   = (state_q == ST_IDLE);
    wire st_burst  = (state_q == ST_BURST);
    wire st_low    = (state_q == ST_PD) || (state_q == ST_SR);
    wire cke_hold  = (hold_q != 4'h0);
    wire chop      = otf_enable ? ~req_full : 1'b0;
    wire mr3_write = (req_op == OP_MRS) && (req_bank == `MR3_BA);

    // Acceptance: bursts are never cut, CKE honours its minimum
    wire legal_low = st_low ? is_exit : ~is_exit;
    wire legal_mpr = ~mpr_q || (req_op == OP_RD) || mr3_write
                     || is_idle;
    wire legal_sre = ~is_sre || (open_q == 8'h00);
    wire legal_pde = ~is_pde || ~st_burst;
    wire busy      = (st_burst && ~is_idle) || cke_hold;
    wire legal     = legal_low && legal_mpr && legal_sre && legal_pde;

    // Wait for CKE to be up first, else a command rides a rising CKE edge
    wire   cke_up      = cke_q || st_low;
    assign req_ready   = clk_en && ~busy && rst_n_q && cke_up;
    wire   take        = req_valid && req_ready && legal;
    wire   refuse      = req_valid && req_ready && ~legal;

    wire [3:0] strb    = strobes(req_op);
    wire       new_cke = is_sre || is_pde ? 1'b0
                         : (is_exit ? 1'b1 : cke_q);

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (take && is_burst) begin
                    state_d = ST_BURST;
                end else if (take && is_sre) begin
                    state_d = ST_SR;
                end else if (take && is_pde) begin
                    state_d = ST_PD;
                end
            end
            ST_BURST: begin
                if (burst_q == 4'h1) begin
                    state_d = ST_IDLE;
                end
            end
            ST_PD: begin
                if (take && is_exit) begin
                    state_d = ST_IDLE;
                end
            end
            ST_SR: begin
                if (take && is_exit) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            rst_n_q <= 1'b0;
        end else if (clk_en) begin
            state_q <= state_d;
            rst_n_q <= ~dram_reset_req;
        end
    end

    // Pin registers; idle cycles present no-operation with defined levels
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cke_q   <= 1'b0;
            cs_n_q  <= 1'b1;
            ras_n_q <= 1'b1;
            cas_n_q <= 1'b1;
            we_n_q  <= 1'b1;
            ba_q    <= '0;
            addr_q  <= '0;
        end else if (clk_en) begin
            if (take) begin
                cke_q   <= new_cke;
                {cs_n_q, ras_n_q, cas_n_q, we_n_q} <= strb;
                ba_q    <= req_bank;
                addr_q  <= req_addr;
                if (req_op == OP_PRE || req_op == OP_ALL_BANK_CLOSE_CMD) begin
                    addr_q[`AP_BIT] <= (req_op == OP_ALL_BANK_CLOSE_CMD);
                end
                if (is_burst) begin
                    addr_q[`AP_BIT] <= req_auto_close;
                    addr_q[`BC_BIT] <= otf_enable ? req_full : 1'b1;
                end
            end else begin
                if (rst_n_q && ~st_low) begin
                    cke_q <= 1'b1;
                end
                {cs_n_q, ras_n_q, cas_n_q, we_n_q} <= 4'h7;
            end
        end
    end

    // Burst length, CKE minimum and bank bookkeeping
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            burst_q <= 4'h0;
            hold_q  <= 4'h0;
            mpr_q   <= 1'b0;
            open_q  <= 8'h00;
        end else if (clk_en) begin
            if (take && is_burst) begin
                burst_q <= chop ? `CHOP_CYC : `BURST_CYC;
            end else if (burst_q != 4'h0) begin
                burst_q <= burst_q - 4'h1;
            end
            if (take && (new_cke != cke_q)) begin
                hold_q <= `CKE_MIN_CYC;
            end else if (cke_hold) begin
                hold_q <= hold_q - 4'h1;
            end
            if (take && mr3_write) begin
                mpr_q <= req_addr[`MPR_BIT];
            end
            if (take) begin
                if (req_op == OP_ACT) begin
                    open_q[req_bank] <= 1'b1;
                end else if (req_op == OP_ALL_BANK_CLOSE_CMD) begin
                    open_q <= 8'h00;
                end else if (req_op == OP_PRE) begin
                    open_q[req_bank] <= 1'b0;
                end else if (is_burst && req_auto_close && ~mpr_q) begin
                    open_q[req_bank] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            req_refused <= 1'b0;
        end else if (clk_en) begin
            req_refused <= refuse;
        end
    end

    assign cke          = cke_q;
    assign cs_n         = cs_n_q;
    assign ras_n        = ras_n_q;
    assign cas_n        = cas_n_q;
    assign we_n         = we_n_q;
    assign ba           = ba_q;
    assign addr         = addr_q;
    assign dram_reset_n = rst_n_q;
    assign odt_allowed  = (state_q != ST_SR);
    assign mpr_active   = mpr_q;
    assign banks_open   = (open_q != 8'h00);
endmodule

// ---- bench/ddr3_cmd_issuer_monitor.sv ----
// Pin timing checks for the command issuer
`timescale 1ns/100ps
module ddr3_cmd_issuer_monitor
    import ddr3_cmd_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic        req_valid,
    input wire logic        req_ready,
    input wire op_e         req_op,
    input wire logic        req_auto_close,
    input wire logic        cke,
    input wire logic        cs_n,
    input wire logic        ras_n,
    input wire logic        cas_n,
    input wire logic        we_n,
    input wire logic [14:0] addr,
    input wire logic        odt_allowed,
    input wire logic        mpr_active
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    wire [3:0] pins = {cs_n, ras_n, cas_n, we_n};
    // Pattern mode refuses most ops, so only plain-mode takes are judged
    sequence s_take(op_e op);
        req_valid && req_ready && req_op == op && cke && !mpr_active;
    endsequence
    property p_act; s_take(OP_ACT) |=> pins == 4'h3 ##1 pins == 4'h7; endproperty
    a_act: assert property (p_act) else $error("activate pins");
    property p_mrs; s_take(OP_MRS) |=> pins == 4'h0; endproperty
    a_mrs: assert property (p_mrs) else $error("mode set pins");
    property p_all_bank_close_cmd; s_take(OP_ALL_BANK_CLOSE_CMD) |=> pins == 4'h2 && addr[10]; endproperty
    a_all_bank_close_cmd: assert property (p_all_bank_close_cmd) else $error("close all pins");
    property p_wr;
        s_take(OP_WR) |=> pins == 4'h4 && addr[10] == $past(req_auto_close);
    endproperty
    a_wr: assert property (p_wr) else $error("write pins");
    property p_rd; s_take(OP_RD) |=> pins == 4'h5; endproperty
    a_rd: assert property (p_rd) else $error("read pins");
    property p_busy; s_take(OP_WR) |=> !req_ready [*2]; endproperty
    a_busy: assert property (p_busy) else $error("burst cut");
    property p_sre; $fell(cke) && pins == 4'h1 |-> ##[0:1] !odt_allowed; endproperty
    a_sre: assert property (p_sre) else $error("odt in refresh");
    property p_pd;
        $changed(cke) && !cs_n |-> pins == 4'h7 || (pins == 4'h1 && !cke);
    endproperty
    a_pd: assert property (p_pd) else $error("cke edge cmd");
endmodule

bind ddr3_cmd_issuer ddr3_cmd_issuer_monitor i_mon (.*);

// ---- bench/ddr3_dev_model.sv ----
// Behavioural device that turns the command pins into one code per edge
`timescale 1ns/100ps
module ddr3_dev_model
    import ddr3_cmd_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        dram_reset_n,
    input  wire logic        cke,
    input  wire logic [3:0]  pins,
    input  wire logic [14:0] addr,
    output op_e              last_op,
    output logic [14:0]      last_a
);
    logic cke_q;
    logic sr_q;
    op_e  op;
    always_comb begin
        op = OP_NOP;
        if (cke_q && !cke)
            op = pins == 4'h1 ? OP_SRE : OP_PDE;
        else if (!cke_q && cke)
            op = sr_q ? OP_SRX : OP_PDX;
        else if (cke)
            case (pins)
                4'h0: op = OP_MRS;
                4'h1: op = OP_REF;
                4'h2: op = addr[10] ? OP_ALL_BANK_CLOSE_CMD : OP_PRE;
                4'h3: op = OP_ACT;
                4'h4: op = OP_WR;
                4'h5: op = OP_RD;
                4'h6: op = OP_ZQ;
                default: op = OP_NOP;
            endcase
    end
    always_ff @(posedge sys_clk or negedge dram_reset_n) begin
        if (!dram_reset_n) begin
            cke_q   <= 1'h0;
            sr_q    <= 1'h0;
            last_op <= OP_NOP;
            last_a  <= 15'h0;
        end else begin
            cke_q <= cke;
            if (op != OP_NOP) begin
                last_op <= op;
                last_a  <= addr;
                sr_q    <= op == OP_SRE;
            end
        end
    end
endmodule

// ---- bench/ddr3_cmd_issuer_tb_top.sv ----
// Self-checking bench for the command issuer
`timescale 1ns/100ps
module ddr3_cmd_issuer_tb_top import ddr3_cmd_pkg::*;;
    logic        sys_clk;
    logic        sys_rst = 1'h1;
    logic        clk_en = 1'h1;
    logic        req_valid = 1'h0;
    op_e         req_op = OP_NOP;
    logic [2:0]  req_bank = 3'h0;
    logic [14:0] req_addr = 15'h05A5;
    logic        req_auto_close = 1'h0;
    logic        req_full = 1'h0;
    logic        otf_enable = 1'h0;
    logic        dram_reset_req = 1'h0;
    logic        req_ready, req_refused, cke, cs_n, ras_n, cas_n, we_n;
    logic        dram_reset_n, odt_allowed, mpr_active, banks_open, refused;
    logic [2:0]  ba;
    logic [14:0] addr, last_a;
    op_e         last_op;
    int          error_cnt = 0;
    int          check_count = 0;
    ddr3_cmd_issuer i_ddr3_cmd_issuer (.*);
    ddr3_dev_model i_ddr3_dev_model (.sys_clk, .dram_reset_n, .cke,
        .pins({cs_n, ras_n, cas_n, we_n}), .addr, .last_op, .last_a);
    initial begin
        sys_clk = 1'h0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic test_done();
        if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cmp_bit(string nm, logic exp, logic got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %b got %b", nm, exp, got);
        end
    endtask
    task automatic cmp_op(string nm, op_e exp, op_e got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask
    // Holds the request until ready, so busy spans are waited out
    task automatic issue(op_e op, logic ap, logic full);
        int n;
        n = 0;
        @(negedge sys_clk);
        req_op = op;
        req_auto_close = ap;
        req_full = full;
        req_valid = 1'h1;
        while (req_ready !== 1'h1 && n < 50) begin
            @(negedge sys_clk);
            n++;
        end
        cmp_bit("ready", 1'h1, req_ready);
        @(negedge sys_clk);
        refused = req_refused;
        req_valid = 1'h0;
        @(negedge sys_clk);
    endtask
    task automatic t_otf();
        issue(OP_ACT, 1'h0, 1'h0);
        cmp_op("op", OP_ACT, last_op);
        cmp_bit("banks_open", 1'h1, banks_open);
        otf_enable = 1'h1;
        issue(OP_RD, 1'h0, 1'h0);
        cmp_bit("chop", 1'h0, last_a[12]);
        issue(OP_WR, 1'h1, 1'h1);
        cmp_bit("full", 1'h1, last_a[12]);
        cmp_bit("ap", 1'h1, last_a[10]);
        otf_enable = 1'h0;
        issue(OP_RD, 1'h0, 1'h0);
        cmp_bit("fixed", 1'h1, last_a[12]);
    endtask
    task automatic t_cmds();
        op_e ops[7] = '{OP_MRS, OP_ACT, OP_WR, OP_RD, OP_PRE, OP_ZQ, OP_ALL_BANK_CLOSE_CMD};
        for (int i = 0; i < 7; i++) begin
            issue(ops[i], i[0], 1'h1);
            cmp_op("op", ops[i], last_op);
            if (i inside {2, 3}) cmp_bit("ap", i[0], last_a[10]);
        end
    endtask
    task automatic t_mpr();
        req_bank = 3'h3;
        issue(OP_MRS, 1'h0, 1'h0);
        cmp_bit("mpr_on", 1'h1, mpr_active);
        cmp_bit("ba", 1'h1, ba[1]);
        issue(OP_ACT, 1'h0, 1'h0);
        cmp_bit("refused", 1'h1, refused);
        req_addr = 15'h0000;
        issue(OP_MRS, 1'h0, 1'h0);
        cmp_bit("mpr_off", 1'h0, mpr_active);
        req_addr = 15'h05A5;
        req_bank = 3'h0;
    endtask
    task automatic t_sr();
        cmp_bit("banks_open", 1'h0, banks_open);
        issue(OP_SRE, 1'h0, 1'h0);
        cmp_op("op", OP_SRE, last_op);
        cmp_bit("odt", 1'h0, odt_allowed);
        issue(OP_ACT, 1'h0, 1'h0);
        cmp_bit("refused", 1'h1, refused);
        issue(OP_SRX, 1'h0, 1'h0);
        cmp_op("op", OP_SRX, last_op);
        cmp_bit("odt", 1'h1, odt_allowed);
    endtask
    task automatic t_pd();
        issue(OP_PDE, 1'h0, 1'h0);
        cmp_op("op", OP_PDE, last_op);
        issue(OP_PDX, 1'h0, 1'h0);
        cmp_op("op", OP_PDX, last_op);
        issue(OP_NOP, 1'h0, 1'h0);
        issue(OP_DES, 1'h0, 1'h0);
        cmp_op("op", OP_PDX, last_op);
        issue(OP_SRX, 1'h0, 1'h0);
        cmp_bit("refused", 1'h1, refused);
    endtask
    task automatic t_rst();
        @(negedge sys_clk);
        dram_reset_req = 1'h1;
        repeat (2) @(negedge sys_clk);
        cmp_bit("reset_n", 1'h0, dram_reset_n);
        dram_reset_req = 1'h0;
    endtask
    initial begin
        repeat (8) @(negedge sys_clk);
        sys_rst = 1'h0;
        t_otf();
        t_cmds();
        t_mpr();
        t_sr();
        t_pd();
        t_rst();
        test_done();
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        error_cnt++;
        test_done();
    end
endmodule
